// ===== src/acs_map.svh
// Register indices, field positions, reset values and sizes of the selector
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH

// Register indices; byte address is four times the index
`define ACS_IDX_DLL 8'h52
`define ACS_IDX_SRC 8'h53
`define ACS_IDX_PHS 8'h64
`define ACS_IDX_STAT 8'h70
`define ACS_IDX_AUX 8'h71

// Field positions
`define ACS_B_EN_DLL 7
`define ACS_B_EN_DUTY 6
`define ACS_B_EN_OCLK 5
`define ACS_B_DLL_RST 4
`define ACS_B_SRC 0
`define ACS_B_OUTCLK_PHASE_DELAY_ENABLE 7
`define ACS_B_DECIM 0
`define ACS_F_PH_MSB 2
`define ACS_F_PH_LSB 0

// Reset values; the loop starts held in reset
`define ACS_RST_DLL 8'h10
`define ACS_RST_SRC 8'h00
`define ACS_RST_PHS 8'h00
`define ACS_RST_AUX 8'h00

// Sizes
`define ACS_DUTY_CW 8
`define ACS_DLY_TAPS 8

`endif

// ===== src/acs_pkg.sv
// Types shared by the clock selector modules
package acs_pkg;
	typedef logic [31:0] acs_word_t;
	typedef logic [7:0]  acs_reg_t;
	typedef logic [2:0]  acs_phase_t;
	typedef logic [9:0]  acs_addr_t;
	// Gray order along the usual path: external, corrected, PLL
	typedef enum logic [1:0]
	{
		ACS_SRC_EXT  = 2'h0,
		ACS_SRC_DUTY = 2'h1,
		ACS_SRC_PLL  = 2'h3
	} acs_src_t;
	typedef enum logic [1:0]
	{
		ACS_OUT_BUF = 2'h0,
		ACS_OUT_DLY = 2'h1
	} acs_oclk_t;
endpackage

// ===== src/acs_links.sv
// Interfaces between the selector and its clock mux and duty corrector
interface acs_mux_if;
	logic [3:0] src;
	logic [1:0] want;
	logic [1:0] cur;
	logic       out;
	modport ctl (output src, output want, input cur, input out);
	modport mux (input src, input want, output cur, output out);
endinterface

interface acs_duty_if;
	logic in_clk;
	logic en;
	logic out_clk;
	modport ctl (output in_clk, output en, input out_clk);
	modport fix (input in_clk, input en, output out_clk);
endinterface

// ===== src/acs_clk_mux.sv
// Runt-free selector between four sampled clock sources
module acs_clk_mux
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Sources and selection
	acs_mux_if.mux   m
);
	logic [1:0] cur_r;
	logic       out_r;

	// Swap only while old and new sources and the output are all low
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			cur_r <= 2'h0;
		else if (m.want != cur_r && !out_r && !m.src[cur_r]
			&& !m.src[m.want])
			cur_r <= m.want;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			out_r <= 1'b0;
		else
			out_r <= m.src[cur_r];
	end

	assign m.cur = cur_r;
	assign m.out = out_r;

	chk_mux_no_runt: assert property (
		@(posedge clk_i) disable iff (rst_i)
		$changed(cur_r) |-> !out_r ##1 out_r == $past(m.src[cur_r]))
		else $error("clock mux switched on a high level");
endmodule

// ===== src/acs_duty_fix.sv
// Falling-edge duty corrector for the sampled external clock
`include "acs_map.svh"

module acs_duty_fix
#(
	parameter int CW = `ACS_DUTY_CW
)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Clock in and out
	acs_duty_if.fix  d
);
	logic          prev_r;
	logic          out_r;
	logic [CW-1:0] cnt_r;
	logic [CW-1:0] half_r;
	logic          rise;

	assign rise = d.in_clk && !prev_r;

	always_ff @(posedge clk_i)
	begin
		if (rst_i || !d.en)
		begin
			prev_r <= 1'b0;
			cnt_r  <= '0;
			half_r <= '0;
		end
		else
		begin
			prev_r <= d.in_clk;
			if (rise)
			begin
				cnt_r  <= {{(CW-1){1'b0}}, 1'b1};
				half_r <= cnt_r >> 1;
			end
			else if (cnt_r != {CW{1'b1}})
				cnt_r <= cnt_r + 1'b1;
		end
	end

	// Rising edge passes as is; falling edge moves to half a period
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			out_r <= 1'b0;
		else if (!d.en || rise)
			out_r <= d.in_clk;
		else if (half_r != '0 && cnt_r >= half_r)
			out_r <= 1'b0;
		else if (half_r == '0 && !d.in_clk)
			out_r <= 1'b0;
	end

	assign d.out_clk = out_r;

	chk_duty_rise_kept: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(d.en && rise) |=> out_r)
		else $error("corrected clock lost its rising edge");
endmodule

// ===== src/acs_clock_select.sv
// Sampling and output data clock selection with register access
//
// The Wishbone register port is this design's own decision.
`include "acs_map.svh"

module acs_clock_select
#(
	parameter int TAPS = `ACS_DLY_TAPS
)
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  acs_pkg::acs_addr_t wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  acs_pkg::acs_word_t wb_dat_i,
	output acs_pkg::acs_word_t wb_dat_o,
	output logic             wb_ack_o,
	// Clock pins, sampled
	input  wire logic        ext_clk_i,
	input  wire logic        pll_clk_i,
	// Clocks and state out
	output logic             sample_clk_o,
	output logic             output_data_clock_o,
	output logic             pll_ref_o,
	output logic             dll_run_o
);
	import acs_pkg::*;

	acs_mux_if  smp_if ();
	acs_mux_if  oclk_if ();
	acs_duty_if duty_if ();

	acs_reg_t   dll_r;
	acs_reg_t   src_r;
	acs_reg_t   phs_r;
	acs_reg_t   aux_r;
	logic       ext_m_r;
	logic       ext_s_r;
	logic       pll_m_r;
	logic       pll_s_r;
	logic       smp_prev_r;
	logic       dec_clk_r;
	logic [TAPS-1:0] dly_r;
	logic       wr_go;
	logic       dll_active;
	logic       duty_en;
	logic       decim;
	logic       use_dly;
	logic       dly_in;
	logic       delayed;
	acs_phase_t phase;
	acs_src_t   smp_want;
	acs_oclk_t  oclk_want;

	// Register index match on a word-aligned byte address
	function automatic logic hit(input acs_addr_t a, input acs_reg_t idx);
		hit = (a[9:2] == idx) && (a[1:0] == 2'h0);
	endfunction

	function automatic acs_reg_t rd_val(input acs_addr_t a);
		acs_reg_t v;
		v = 8'h00;
		if (hit(a, `ACS_IDX_DLL))
			v = dll_r;
		else if (hit(a, `ACS_IDX_SRC))
			v = src_r;
		else if (hit(a, `ACS_IDX_PHS))
			v = phs_r;
		else if (hit(a, `ACS_IDX_AUX))
			v = aux_r;
		else if (hit(a, `ACS_IDX_STAT))
			v = {3'h0, duty_en, oclk_if.cur[0], smp_if.cur, dll_active};
		rd_val = v;
	endfunction

	// Bus: ack one cycle after the request, writes land on the ack edge
	assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o
		&& wb_sel_i[0];

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_dat_o <= 32'h0000_0000;
		else if (wb_cyc_i && wb_stb_i && !wb_ack_o)
			wb_dat_o <= {24'h00_0000, rd_val(wb_adr_i)};
	end

	// Unmapped writes are acknowledged and dropped
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			dll_r <= `ACS_RST_DLL;
			src_r <= `ACS_RST_SRC;
			phs_r <= `ACS_RST_PHS;
			aux_r <= `ACS_RST_AUX;
		end
		else if (wr_go)
		begin
			if (hit(wb_adr_i, `ACS_IDX_DLL))
				dll_r <= wb_dat_i[7:0];
			if (hit(wb_adr_i, `ACS_IDX_SRC))
				src_r <= {7'h00, wb_dat_i[`ACS_B_SRC]};
			if (hit(wb_adr_i, `ACS_IDX_PHS))
				phs_r <= wb_dat_i[7:0];
			if (hit(wb_adr_i, `ACS_IDX_AUX))
				aux_r <= {7'h00, wb_dat_i[`ACS_B_DECIM]};
		end
	end

	// Clock pins come from outside this domain
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ext_m_r <= 1'b0;
			ext_s_r <= 1'b0;
			pll_m_r <= 1'b0;
			pll_s_r <= 1'b0;
		end
		else
		begin
			ext_m_r <= ext_clk_i;
			ext_s_r <= ext_m_r;
			pll_m_r <= pll_clk_i;
			pll_s_r <= pll_m_r;
		end
	end

	// Loop runs only when enabled, out of reset and fed by the pin
	assign dll_active = dll_r[`ACS_B_EN_DLL] && !dll_r[`ACS_B_DLL_RST]
		&& !src_r[`ACS_B_SRC];
	assign duty_en = dll_active && dll_r[`ACS_B_EN_DUTY];
	assign decim = aux_r[`ACS_B_DECIM];

	always_comb
	begin
		if (src_r[`ACS_B_SRC])
			smp_want = ACS_SRC_PLL;
		else if (duty_en)
			smp_want = ACS_SRC_DUTY;
		else
			smp_want = ACS_SRC_EXT;
	end

	assign duty_if.in_clk = ext_s_r;
	assign duty_if.en = duty_en;

	acs_duty_fix #(.CW(`ACS_DUTY_CW)) u_duty
	(
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d     (duty_if)
	);

	assign smp_if.src = {pll_s_r, 1'b0, duty_if.out_clk, ext_s_r};
	assign smp_if.want = smp_want;

	acs_clk_mux u_smp_mux
	(
		.clk_i (clk_i),
		.rst_i (rst_i),
		.m     (smp_if)
	);

	// Decimated output clock: divide the sampling clock by two
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			smp_prev_r <= 1'b0;
			dec_clk_r  <= 1'b0;
		end
		else
		begin
			smp_prev_r <= smp_if.out;
			if (smp_if.out && !smp_prev_r)
				dec_clk_r <= !dec_clk_r;
		end
	end

	// Phase delay: tap of a delay line, one clk_i step per code
	always_comb
	begin
		if (!phs_r[`ACS_B_OUTCLK_PHASE_DELAY_ENABLE])
			phase = 3'h0;
		else if (decim)
			phase = phs_r[`ACS_F_PH_MSB:`ACS_F_PH_LSB];
		else
			phase = dll_r[`ACS_F_PH_MSB:`ACS_F_PH_LSB];
	end

	assign dly_in = decim ? dec_clk_r : smp_if.out;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			dly_r <= '0;
		else
			dly_r <= {dly_r[TAPS-2:0], dly_in};
	end

	assign delayed = (phase == 3'h0) ? dly_in : dly_r[phase - 3'h1];

	// Buffered pin clock unless decimation, PLL or loop output is in use
	assign use_dly = decim || src_r[`ACS_B_SRC]
		|| (dll_active && dll_r[`ACS_B_EN_OCLK]);
	assign oclk_want = use_dly ? ACS_OUT_DLY : ACS_OUT_BUF;
	assign oclk_if.src = {2'b00, delayed, ext_s_r};
	assign oclk_if.want = oclk_want;

	acs_clk_mux u_oclk_mux
	(
		.clk_i (clk_i),
		.rst_i (rst_i),
		.m     (oclk_if)
	);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sample_clk_o        <= 1'b0;
			output_data_clock_o <= 1'b0;
			pll_ref_o           <= 1'b0;
			dll_run_o           <= 1'b0;
		end
		else
		begin
			sample_clk_o        <= smp_if.out;
			output_data_clock_o <= oclk_if.out;
			pll_ref_o <= src_r[`ACS_B_SRC] && ext_s_r;
			dll_run_o <= dll_active;
		end
	end

	chk_reset_ext_default: assert property (
		@(posedge clk_i)
		$fell(rst_i) |-> smp_want == ACS_SRC_EXT && !dll_run_o
			&& oclk_want == ACS_OUT_BUF)
		else $error("selector not on external clock after reset");

	chk_loop_enable: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(dll_r[`ACS_B_EN_DLL] && !dll_r[`ACS_B_DLL_RST]
			&& !src_r[`ACS_B_SRC]) |=> dll_run_o)
		else $error("enabled loop not running");

	chk_loop_reset_holds: assert property (
		@(posedge clk_i) disable iff (rst_i)
		dll_r[`ACS_B_DLL_RST] [*2] |-> !dll_run_o)
		else $error("loop runs while held in reset");

	chk_duty_needs_loop: assert property (
		@(posedge clk_i) disable iff (rst_i)
		smp_if.cur == ACS_SRC_DUTY |-> $past(dll_active)
			|| $past(smp_if.cur) == ACS_SRC_DUTY)
		else $error("corrected clock chosen without the loop");

	chk_pll_reference: assert property (
		@(posedge clk_i) disable iff (rst_i)
		src_r[`ACS_B_SRC] |-> smp_want == ACS_SRC_PLL
			##1 pll_ref_o == $past(ext_s_r))
		else $error("PLL reference or selection wrong");

	chk_phase_gate: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(!phs_r[`ACS_B_OUTCLK_PHASE_DELAY_ENABLE] && oclk_if.cur == ACS_OUT_DLY)
			|-> ##1 oclk_if.out == $past(dly_in))
		else $error("delay applied with phase delay disabled");

	chk_decim_phase: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(decim && phs_r[`ACS_B_OUTCLK_PHASE_DELAY_ENABLE])
			|-> phase == phs_r[`ACS_F_PH_MSB:`ACS_F_PH_LSB])
		else $error("decimation phase field not used");

	chk_loop_phase: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(!decim && phs_r[`ACS_B_OUTCLK_PHASE_DELAY_ENABLE])
			|-> phase == dll_r[`ACS_F_PH_MSB:`ACS_F_PH_LSB])
		else $error("loop phase field not used");

	chk_default_out_buf: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(!use_dly && oclk_if.cur == ACS_OUT_BUF) [*2]
			|-> output_data_clock_o == $past(ext_s_r, 2))
		else $error("default output clock not from input buffer");

	chk_wb_write_lands: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(wr_go && hit(wb_adr_i, `ACS_IDX_DLL))
			|=> dll_r == $past(wb_dat_i[7:0]))
		else $error("loop control write lost");

	chk_wb_ack_pulse: assert property (
		@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

	chk_ref_idle_ext: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!src_r[`ACS_B_SRC] |=> !pll_ref_o)
		else $error("PLL reference driven on the external path");

	chk_sample_ext_path: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(smp_if.cur == ACS_SRC_EXT) [*2]
			|-> sample_clk_o == $past(ext_s_r, 2))
		else $error("sampling clock not from the external pin");

	chk_decim_toggle: assert property (
		@(posedge clk_i) disable iff (rst_i)
		$changed(dec_clk_r) |-> $past(smp_if.out && !smp_prev_r))
		else $error("decimated clock moved off a sampling edge");
endmodule

// ===== testbench/acs_ext_src.sv
// Free-running external and PLL clock pins seen by the selector
module acs_ext_src
#(
	parameter int EXT_HALF = 5,
	parameter int PLL_HALF = 2
)
(
	// Clock
	input  wire logic clk_i,
	// Clock pins
	output logic      ext_clk_o,
	output logic      pll_clk_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int ce = 0;
	int cp = 0;
	// A sampling clock runs free, so neither pin ever stops
	initial
	begin
		ext_clk_o = 1'b0;
		pll_clk_o = 1'b0;
	end
	always @(posedge clk_i)
	begin
		ce <= (ce >= EXT_HALF - 1) ? 0 : ce + 1;
		cp <= (cp >= PLL_HALF - 1) ? 0 : cp + 1;
		if (ce >= EXT_HALF - 1)
			ext_clk_o <= ~ext_clk_o;
		if (cp >= PLL_HALF - 1)
			pll_clk_o <= ~pll_clk_o;
	end
endmodule

// ===== testbench/tb_top.sv
// Self-checking bench for the clock source selector
`include "acs_map.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import acs_pkg::*;
	logic        clk_i;
	logic        rst_i;
	logic        wb_cyc_i;
	logic        wb_stb_i;
	logic        wb_we_i;
	acs_addr_t   wb_adr_i;
	logic [3:0]  wb_sel_i;
	acs_word_t   wb_dat_i;
	acs_word_t   wb_dat_o;
	logic        wb_ack_o;
	logic        ext_clk;
	logic        pll_clk;
	logic        sample_clk_o;
	logic        output_data_clock_o;
	logic        pll_ref_o;
	logic        dll_run_o;
	int          errors = 0;
	int          total_checks = 0;
	int          seed = 32'h3c4825e9;
	acs_word_t   exp_q[$];

	acs_clock_select i_acs_clock_select (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_clk_i(ext_clk),
		.pll_clk_i(pll_clk), .sample_clk_o(sample_clk_o),
		.output_data_clock_o(output_data_clock_o),
		.pll_ref_o(pll_ref_o), .dll_run_o(dll_run_o));
	acs_ext_src i_acs_ext_src (.clk_i(clk_i), .ext_clk_o(ext_clk),
		.pll_clk_o(pll_clk));

	task automatic finish_test();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic fail(input string m);
		errors++;
		$display("wrong value at %0t: %s", $time, m);
	endtask
	task automatic chk(input logic ok, input string m);
		total_checks++;
		if (ok !== 1'b1)
			fail(m);
	endtask
	task automatic wb(input logic we, input acs_reg_t idx,
		input acs_reg_t d, input logic [3:0] sel);
		int n;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= {idx, 2'b00};
		wb_dat_i <= {24'h000000, d};
		wb_sel_i <= sel;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (wb_ack_o !== 1'b1 && n < 20);
		if (n >= 20)
		begin
			fail("no ack");
			finish_test();
		end
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wr(input acs_reg_t idx, input acs_reg_t d);
		wb(1'b1, idx, d, 4'h1);
	endtask
	task automatic rd(input acs_reg_t idx, input acs_reg_t e);
		exp_q.push_back({24'h000000, e});
		wb(1'b0, idx, 8'h00, 4'hF);
	endtask
	// Toggles of the sampling clock, the reference and the output clock over 60 cycles
	task automatic count(output int ns, output int nr, output int no);
		logic ps;
		logic pr;
		logic po;
		ns = 0;
		nr = 0;
		no = 0;
		ps = sample_clk_o;
		pr = pll_ref_o;
		po = output_data_clock_o;
		repeat (60)
		begin
			@(posedge clk_i);
			ns += (sample_clk_o !== ps);
			nr += (pll_ref_o !== pr);
			no += (output_data_clock_o !== po);
			ps = sample_clk_o;
			pr = pll_ref_o;
			po = output_data_clock_o;
		end
	endtask
	// Output clock against the sampling clock d cycles earlier
	task automatic lag_chk(input int d, output int bad);
		logic [15:0] h;
		h = 16'h0000;
		bad = 0;
		for (int i = 0; i < 56; i++)
		begin
			@(posedge clk_i);
			h = {h[14:0], sample_clk_o};
			if (i >= 16)
				bad += (output_data_clock_o !== h[d]);
		end
	endtask

	initial
	begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	always @(posedge clk_i)
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
		begin
			total_checks++;
			if (exp_q.size() == 0)
				fail("unexpected read");
			else if (wb_dat_o !== exp_q.pop_front())
				fail("read data");
		end

	initial
	begin
		int ns;
		int nr;
		int no;
		int bad;
		acs_reg_t r;
		rst_i = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = '0;
		wb_sel_i = 4'h0;
		wb_dat_i = '0;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk(dll_run_o === 1'b0 && pll_ref_o === 1'b0, "reset out");
		repeat (20) @(posedge clk_i);
		rd(`ACS_IDX_DLL, `ACS_RST_DLL);
		rd(`ACS_IDX_SRC, 8'h00);
		rd(`ACS_IDX_PHS, 8'h00);
		rd(`ACS_IDX_AUX, 8'h00);
		rd(`ACS_IDX_STAT, 8'h00);
		rd(8'h7F, 8'h00);
		count(ns, nr, no);
		chk(ns >= 10 && ns <= 14 && nr == 0, "external path");
		chk(no >= 10 && no <= 14, "buffered output clock");
		repeat (4)
		begin
			r = acs_reg_t'($random(seed));
			wr(`ACS_IDX_DLL, r);
			rd(`ACS_IDX_DLL, r);
		end
		wb(1'b1, `ACS_IDX_DLL, ~r, 4'h0);
		rd(`ACS_IDX_DLL, r);
		wr(`ACS_IDX_DLL, 8'h10);
		wr(`ACS_IDX_DLL, 8'h80);
		repeat (8) @(posedge clk_i);
		chk(dll_run_o === 1'b1, "loop on");
		wr(`ACS_IDX_DLL, 8'hC0);
		repeat (40) @(posedge clk_i);
		rd(`ACS_IDX_STAT, 8'h13);
		count(ns, nr, no);
		chk(ns >= 10 && ns <= 14, "corrected edges");
		chk(no >= 10 && no <= 14, "output clock on buffer");
		wr(`ACS_IDX_DLL, 8'hE0);
		repeat (40) @(posedge clk_i);
		rd(`ACS_IDX_STAT, 8'h1B);
		wr(`ACS_IDX_DLL, 8'hE3);
		wr(`ACS_IDX_PHS, 8'h80);
		lag_chk(4, bad);
		chk(bad == 0, "loop phase delay");
		wr(`ACS_IDX_DLL, 8'h90);
		repeat (8) @(posedge clk_i);
		chk(dll_run_o === 1'b0, "loop held");
		repeat (40) @(posedge clk_i);
		rd(`ACS_IDX_STAT, 8'h00);
		wr(`ACS_IDX_AUX, 8'h01);
		wr(`ACS_IDX_PHS, 8'h85);
		repeat (40) @(posedge clk_i);
		rd(`ACS_IDX_STAT, 8'h08);
		rd(`ACS_IDX_PHS, 8'h85);
		count(ns, nr, no);
		chk(no >= 5 && no <= 7, "decimated output clock");
		wr(`ACS_IDX_AUX, 8'h00);
		wr(`ACS_IDX_PHS, 8'h00);
		wr(`ACS_IDX_DLL, 8'hC0);
		wr(`ACS_IDX_SRC, 8'h01);
		repeat (40) @(posedge clk_i);
		rd(`ACS_IDX_STAT, 8'h0E);
		chk(dll_run_o === 1'b0, "loop off on PLL");
		count(ns, nr, no);
		chk(ns >= 26 && ns <= 32, "PLL sampling");
		chk(no >= 26 && no <= 32, "PLL output clock");
		chk(nr >= 10 && nr <= 14, "PLL reference");
		wr(`ACS_IDX_STAT, 8'hFF);
		rd(`ACS_IDX_STAT, 8'h0E);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(`ACS_IDX_SRC, 8'h00);
		rd(`ACS_IDX_DLL, `ACS_RST_DLL);
		repeat (2) @(posedge clk_i);
		if (exp_q.size() != 0)
			fail("reads left");
		finish_test();
	end
endmodule
